/* File: hdl/sub_test_alu.v */
// Subtract and logical-compare datapath slice with opcode decode.
//
// Overview of operation
// RULE1 - 2C/2D subtract immediate from accumulator
// RULE2 - 80/81/83 reg 5 subtract immediate
// RULE3 - 28..2B register subtract, direction by opcode
// RULE4 - Difference written to first operand, flags updated
// RULE5 - Byte immediate sign-extended for word operand
// RULE6 - Overflow flag on signed result overflow
// RULE7 - Carry flag on borrow out of top
// RULE8 - Zero flag when result is zero
// RULE9 - Nibble carry flag on low nibble borrow
// RULE10 - Accumulator immediate takes 3 or 4 clocks
// RULE11 - A8/A9 compare accumulator with immediate
// RULE12 - F6/F7 reg 0 compare with immediate
// RULE13 - 84/85 compare register with operand
// RULE14 - Compare result ANDed and discarded
// RULE15 - Compare clears overflow and carry flags
// RULE16 - Sign from top bit, parity of low byte
// RULE17 - Direction, interrupt, trap flags untouched
////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "sub_test_defines.vh"
module sub_test_alu (
   // Clock and reset.
   input  wire        clk,
   input  wire        rst_n,
   // Request from the instruction decoder.
   input  wire        start,
   input  wire [7:0]  opcode,
   input  wire [2:0]  modrm_reg,
   input  wire        rm_is_mem,
   input  wire        bus8,
   input  wire [15:0] immediate,
   // Operands from the register file.
   input  wire [15:0] accumulator_word,
   input  wire [15:0] rm_operand,
   input  wire [15:0] reg_operand,
   // Status and answer.
   output wire        busy,
   output reg         done,
   output reg         illegal,
   output reg  [15:0] result,
   output reg         wr_en,
   output reg  [1:0]  wr_dest,
   output reg         wr_word,
   output reg         overflow_flag,
   output reg         carry_borrow_flag,
   output reg         zero_flag,
   output reg         nibble_carry_flag,
   output reg         sign_flag,
   output reg         parity_flag
);
   localparam ST_IDLE = 2'b01;
   localparam ST_WAIT = 2'b10;
   ////////////////////////////////////////////////////////////////////
   reg        dec_ok;
   reg        dec_test;
   reg        dec_word;
   reg [15:0] op_a;
   reg [15:0] op_b;
   reg [1:0]  dec_dest;
   reg [4:0]  dec_clocks;
   reg [4:0]  dec_xtra;
   reg        dec_mem;
   always @* begin
      dec_ok = 1'b1;
      dec_test = 1'b0;
      dec_word = opcode[0];
      op_a = rm_operand;
      op_b = reg_operand;
      dec_dest = `OPD_RM;
      dec_mem = rm_is_mem;
      dec_clocks = `CLK_REG;
      dec_xtra = `CLK_MEM_EXTRA;
      case (opcode)
         `OPC_SUB_ACC8_I, `OPC_SUB_ACC16_I: begin
            op_a = accumulator_word; // RULE1
            op_b = immediate;
            dec_dest = `OPD_ACC;
            dec_mem = 1'b0;
            dec_clocks = dec_word ? `CLK_ACC16 : `CLK_ACC8; // RULE10
         end
         `OPC_GRP1_8_I, `OPC_GRP1_16_I, `OPC_GRP1_16_SI: begin
            dec_ok = (modrm_reg == `REG_SUB); // RULE2
            dec_word = (opcode != `OPC_GRP1_8_I);
            op_b = immediate;
            if (opcode == `OPC_GRP1_16_SI) begin
               op_b = {immediate[7] ? `HI_ONES : `HI_ZERO,
                       immediate[7:0]}; // RULE5
            end
            dec_clocks = `CLK_IMM_RM;
            dec_xtra = `CLK_SUB_IMM_XTRA;
         end
         `OPC_SUB_RM8_R, `OPC_SUB_RM16_R: begin
            dec_clocks = `CLK_REG; // RULE3
         end
         `OPC_SUB_R8_RM, `OPC_SUB_R16_RM: begin
            op_a = reg_operand; // RULE3
            op_b = rm_operand;
            dec_dest = `OPD_REG;
         end
         `OPC_TST_ACC8_I, `OPC_TST_ACC16_I: begin
            dec_test = 1'b1; // RULE11
            op_a = accumulator_word;
            op_b = immediate;
            dec_mem = 1'b0;
            dec_clocks = dec_word ? `CLK_ACC16 : `CLK_ACC8;
         end
         `OPC_GRP3_8, `OPC_GRP3_16: begin
            dec_ok = (modrm_reg == `REG_TST); // RULE12
            dec_test = 1'b1;
            op_b = immediate;
            dec_clocks = `CLK_IMM_RM;
            dec_xtra = `CLK_TST_MEM_XTRA;
         end
         `OPC_TST_RM8_R, `OPC_TST_RM16_R: begin
            dec_test = 1'b1; // RULE13
         end
         default: begin
            dec_ok = 1'b0;
         end
      endcase
      // Memory forms take longer; word memory on the narrow bus more so.
      if (dec_mem) begin
         dec_clocks = dec_clocks + dec_xtra; // RULE10
         if (bus8 && dec_word) begin
            dec_clocks = dec_clocks + `CLK_MEM_EXTRA_W; // RULE10
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   wire [15:0] f_result;
   wire        f_of;
   wire        f_cf;
   wire        f_zf;
   wire        f_af;
   wire        f_sf;
   wire        f_pf;
   sub_test_flags u_flags (
      .a                 (op_a),
      .b                 (op_b),
      .word              (dec_word),
      .is_test           (dec_test),
      .result            (f_result),
      .overflow_flag     (f_of),
      .carry_borrow_flag (f_cf),
      .zero_flag         (f_zf),
      .nibble_carry_flag (f_af),
      .sign_flag         (f_sf),
      .parity_flag       (f_pf)
   );
   ////////////////////////////////////////////////////////////////////
   reg [1:0]  state;
   reg [4:0]  count;
   reg [15:0] hold_result;
   reg [5:0]  hold_flags;
   reg        hold_wr;
   reg [1:0]  hold_dest;
   reg        hold_word;
   assign busy = (state == ST_WAIT);
   // Results are captured at start so operands may change while busy.
   // Only the six arithmetic flags leave this block, so the direction,
   // interrupt and trap flags can never be disturbed here.
   always @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         count <= 5'h00;
         hold_result <= 16'h0000;
         hold_flags <= 6'h00;
         hold_wr <= 1'b0;
         hold_dest <= `OPD_RM;
         hold_word <= 1'b0;
         done <= 1'b0;
         illegal <= 1'b0;
         result <= 16'h0000;
         wr_en <= 1'b0;
         wr_dest <= `OPD_RM;
         wr_word <= 1'b0;
         overflow_flag <= 1'b0;
         carry_borrow_flag <= 1'b0;
         zero_flag <= 1'b0;
         nibble_carry_flag <= 1'b0;
         sign_flag <= 1'b0;
         parity_flag <= 1'b0;
      end else begin
         done <= 1'b0;
         wr_en <= 1'b0;
         illegal <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (start && !dec_ok) begin
                  illegal <= 1'b1;
               end else if (start) begin
                  hold_result <= f_result;
                  hold_flags <= {f_of, f_cf, f_zf, f_af, f_sf, f_pf};
                  hold_wr <= !dec_test; // RULE14
                  hold_dest <= dec_dest;
                  hold_word <= dec_word;
                  count <= dec_clocks - `CLK_LAST; // RULE10
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (count == `CLK_LAST) begin
                  state <= ST_IDLE;
                  done <= 1'b1;
                  result <= hold_result;
                  wr_en <= hold_wr; // RULE4
                  wr_dest <= hold_dest;
                  wr_word <= hold_word;
                  {overflow_flag, carry_borrow_flag, zero_flag,
                   nibble_carry_flag, sign_flag,
                   parity_flag} <= hold_flags; // RULE17
               end else begin
                  count <= count - `CLK_LAST;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

/* File: hdl/sub_test_defines.vh */
// Constants for the subtract and logical-compare datapath slice.
`ifndef SUB_TEST_DEFINES_VH
`define SUB_TEST_DEFINES_VH
`define OPC_SUB_RM8_R    8'h28
`define OPC_SUB_RM16_R   8'h29
`define OPC_SUB_R8_RM    8'h2a
`define OPC_SUB_R16_RM   8'h2b
`define OPC_SUB_ACC8_I   8'h2c
`define OPC_SUB_ACC16_I  8'h2d
`define OPC_GRP1_8_I     8'h80
`define OPC_GRP1_16_I    8'h81
`define OPC_GRP1_16_SI   8'h83
`define OPC_TST_RM8_R    8'h84
`define OPC_TST_RM16_R   8'h85
`define OPC_TST_ACC8_I   8'ha8
`define OPC_TST_ACC16_I  8'ha9
`define OPC_GRP3_8       8'hf6
`define OPC_GRP3_16      8'hf7
`define REG_SUB          3'h5
`define REG_TST          3'h0
`define HI_ONES          8'hff
`define HI_ZERO          8'h00
`define CLK_ACC8         5'h03
`define CLK_ACC16        5'h04
`define CLK_REG          5'h03
`define CLK_IMM_RM       5'h04
`define CLK_MEM_EXTRA    5'h07
`define CLK_SUB_IMM_XTRA 5'h0c
`define CLK_MEM_EXTRA_W  5'h04
`define CLK_TST_MEM_XTRA 5'h06
`define CLK_LAST         5'h01
`define OPD_RM           2'h0
`define OPD_REG          2'h1
`define OPD_ACC          2'h2
`endif

/* File: hdl/sub_test_flags.v */
// Flag generation for one subtract or logical-compare result.
`timescale 1ns/10ps
`include "sub_test_defines.vh"
module sub_test_flags (
   // Operands and mode.
   input  wire [15:0] a,
   input  wire [15:0] b,
   input  wire        word,
   input  wire        is_test,
   // Result and flags.
   output reg  [15:0] result,
   output reg         overflow_flag,
   output reg         carry_borrow_flag,
   output reg         zero_flag,
   output reg         nibble_carry_flag,
   output reg         sign_flag,
   output reg         parity_flag
);
   reg [16:0] diff;
   reg        msb_a;
   reg        msb_b;
   function msb_of;
      input [15:0] v;
      input        w;
      begin
         msb_of = w ? v[15] : v[7];
      end
   endfunction
   always @* begin
      diff = {1'b0, a} - {1'b0, b};
      if (!word) begin
         diff = {8'h00, 1'b0, a[7:0]} - {8'h00, 1'b0, b[7:0]};
      end
      msb_a = msb_of(a, word);
      msb_b = msb_of(b, word);
      if (is_test) begin
         result = a & b; // RULE14
         if (!word) begin
            result[15:8] = 8'h00;
         end
         overflow_flag = 1'b0; // RULE15
         carry_borrow_flag = 1'b0; // RULE15
         nibble_carry_flag = 1'b0;
      end else begin
         result = diff[15:0]; // RULE4
         if (!word) begin
            result[15:8] = 8'h00;
         end
         // Signed overflow: operand signs differ and result sign flips.
         overflow_flag = (msb_a != msb_b) &&
                         (msb_of(result, word) != msb_a); // RULE6
         carry_borrow_flag = word ? diff[16] : diff[8]; // RULE7
         nibble_carry_flag = (a[3:0] < b[3:0]); // RULE9
      end
      zero_flag = word ? (result == 16'h0000)
                       : (result[7:0] == 8'h00); // RULE8
      sign_flag = msb_of(result, word); // RULE16
      parity_flag = ~^result[7:0]; // RULE16
   end
endmodule

/* File: testbench/regfile_model.sv */
// Register file model that feeds operands and takes write-backs.
`timescale 1ns/10ps
module regfile_model (
   // Clock and operand loading.
   input  wire        clk,
   input  wire        ld,
   input  wire [47:0] ld_val,
   // Write-back from the datapath.
   input  wire        wr_en,
   input  wire        wr_word,
   input  wire [1:0]  wr_dest,
   input  wire [15:0] result,
   // Operands.
   output reg  [15:0] accumulator_word,
   output reg  [15:0] rm_operand,
   output reg  [15:0] reg_operand
);
   // A load wins over a write-back so each test starts from known values.
   always @(posedge clk) begin
      if (ld) begin
         {accumulator_word, rm_operand, reg_operand} <= ld_val;
      end else if (wr_en && wr_dest == 2'h0) begin
         rm_operand <= wr_word ? result : {rm_operand[15:8], result[7:0]};
      end else if (wr_en && wr_dest == 2'h1) begin
         reg_operand <= wr_word ? result : {reg_operand[15:8], result[7:0]};
      end else if (wr_en) begin
         accumulator_word <= wr_word ? result
                           : {accumulator_word[15:8], result[7:0]};
      end
   end
endmodule

/* File: testbench/sub_test_alu_asserts.sv */
// Concurrent checks on the datapath slice ports.
`timescale 1ns/10ps
module sub_test_alu_asserts (
   // Clock and reset.
   input  wire        clk,
   input  wire        rst_n,
   // Request.
   input  wire        start,
   input  wire [7:0]  opcode,
   input  wire [2:0]  modrm_reg,
   input  wire        rm_is_mem,
   // Answer.
   input  wire        busy,
   input  wire        done,
   input  wire        illegal,
   input  wire        wr_en,
   input  wire        wr_word,
   input  wire [15:0] result,
   input  wire        overflow_flag,
   input  wire        carry_borrow_flag,
   input  wire        zero_flag,
   input  wire        sign_flag,
   input  wire        parity_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   acc8_time_a: assert property (
      start && !busy && opcode == 8'h2c |-> ##3 done)
      else $error("byte acc latency");
   acc16_time_a: assert property (
      start && !busy && opcode == 8'h2d |-> ##4 done)
      else $error("word acc latency");
   mem_time_a: assert property (
      start && !busy && opcode == 8'h80 && modrm_reg == 3'h5 && rm_is_mem
      |-> ##16 done)
      else $error("memory sub latency");
   test_flags_a: assert property (
      start && !busy && opcode == 8'ha8
      |-> ##3 (done && !wr_en && !overflow_flag && !carry_borrow_flag))
      else $error("compare flags");
   zero_res_a: assert property (
      done |-> zero_flag == (result == 16'h0000))
      else $error("zero flag");
   parity_low_a: assert property (
      done |-> parity_flag == ~^result[7:0])
      else $error("parity flag");
   sign_word_a: assert property (
      done && wr_word |-> sign_flag == result[15])
      else $error("word sign");
   sign_byte_a: assert property (
      done && !wr_word |-> sign_flag == result[7])
      else $error("byte sign");
   done_pulse_a: assert property (
      done |-> !busy ##1 !done)
      else $error("done pulse");
   bad_op_a: assert property (
      start && !busy
      && (opcode == 8'h00 || (opcode == 8'hf6 && modrm_reg == 3'h1))
      |=> illegal && !done)
      else $error("illegal op");
endmodule
bind sub_test_alu sub_test_alu_asserts i_chk (.*);

/* File: testbench/tb.sv */
// Self-checking bench for the subtract and compare datapath.
`timescale 1ns/10ps
module tb;
   reg         clk, rst_n, start, rm_is_mem, bus8, ld;
   reg  [7:0]  opcode;
   reg  [2:0]  modrm_reg;
   reg  [15:0] immediate;
   reg  [47:0] ld_val;
   wire        busy, done, illegal, wr_en, wr_word, overflow_flag, zero_flag;
   wire        carry_borrow_flag, nibble_carry_flag, sign_flag, parity_flag;
   wire [1:0]  wr_dest;
   wire [15:0] result, accumulator_word, rm_operand, reg_operand;
   integer     err_count, checked, i, j;
   reg  [25:0] notes[$];
   reg  [25:0] me;
   reg  [31:0] seed;
   reg  [63:0] v;
   reg  [7:0]  sw_op;
   reg  [2:0]  sw_reg;
   reg  [5:0]  fl;
   localparam [164:0] TAB = {8'h2c, 3'h0, 8'h2d, 3'h0, 8'h80, 3'h5, 8'h81,
      3'h5, 8'h83, 3'h5, 8'h28, 3'h0, 8'h29, 3'h0, 8'h2a, 3'h0, 8'h2b, 3'h0,
      8'ha8, 3'h0, 8'ha9, 3'h0, 8'hf6, 3'h0, 8'hf7, 3'h0, 8'h84, 3'h0, 8'h85,
      3'h0};
   sub_test_alu i_dut (.*);
   regfile_model i_regs (.*);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
   endfunction
   function automatic [30:0] model(input [7:0] op, input [15:0] ac, rm,
                                   input [15:0] rg, im, input m, b8);
      reg w, t, ai, ri; reg [15:0] a, b, r; reg [16:0] d; reg [4:0] n;
      integer s;
      begin
         w = op[0] | (op == 8'h83);
         t = (op[7:4] == 4'ha) | (op[7:4] == 4'hf) | (op[7:1] == 7'h42);
         ai = (op[7:4] == 4'ha) | (op[7:1] == 7'h16);
         a = ai ? ac : (op[7:1] == 7'h15) ? rg : rm;
         b = (op == 8'h83) ? {{8{im[7]}}, im[7:0]} : (op[7:1] == 7'h15) ? rm
           : (op[7:1] == 7'h14 || op[7:1] == 7'h42) ? rg : im;
         if (!w) begin
            a[15:8] = 8'h00;
            b[15:8] = 8'h00;
         end
         d = {1'b0, a} - {1'b0, b};
         r = t ? a & b : d[15:0];
         if (!w) r[15:8] = 8'h00;
         s = w ? 15 : 7;
         ri = (op[7:4] == 4'h8 && !op[2]) | (op[7:4] == 4'hf);
         n = ai ? 5'h3 + w : ri ? 5'h4 : 5'h3;
         if (m && !ai) n = (ri && !t) ? 5'h10 : 5'h0a;
         if (m && !ai && b8 && w) n = n + 5'h4;
         model = {n, !t, ai ? 2'h2 : (op[7:1] == 7'h15) ? 2'h1 : 2'h0, w,
                  !t && a[s] != b[s] && r[s] != a[s], !t && d[s + 1],
                  r == 16'h0000, !t && a[3:0] < b[3:0], r[s], ~^r[7:0], r};
      end
   endfunction
   task chk(input ok);
      begin
         checked = checked + 1;
         if (!ok) begin
            err_count = err_count + 1;
            $display("[FAIL] %0t mismatch", $time);
         end
      end
   endtask
   task finish_test;
      begin
         $display("errors %0d checks %0d", err_count, checked);
         if (err_count == 0 && checked > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   // A second start while busy must be dropped, so sp repeats it there.
   task run(input [7:0] op, input [2:0] rg, input m, b8, sp,
            input [63:0] vv, input bad);
      reg [30:0] e; integer k;
      begin
         e = model(op, vv[63:48], vv[47:32], vv[31:16], vv[15:0], m, b8);
         @(posedge clk); ld <= 1'b1; ld_val <= vv[63:16];
         @(posedge clk); ld <= 1'b0; start <= 1'b1; opcode <= op;
         modrm_reg <= rg; rm_is_mem <= m; bus8 <= b8; immediate <= vv[15:0];
         if (!bad) notes.push_back(e[25:0]);
         @(posedge clk); start <= sp && !bad;
         k = 0;
         while (k < 40) begin
            @(negedge clk); k = k + 1;
            if (done === 1'b1 || illegal === 1'b1) break;
            @(posedge clk); start <= 1'b0;
         end
         if (bad) chk(illegal === 1'b1 && done === 1'b0 && k == 1);
         else chk(k == e[30:26]);
         if (k == 40) finish_test;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      if (rst_n && done === 1'b1) begin
         if (notes.size() == 0) chk(1'b0);
         else begin
            me = notes.pop_front();
            fl = {overflow_flag, carry_borrow_flag, zero_flag,
                  nibble_carry_flag, sign_flag, parity_flag};
            chk({wr_en, result} === {me[25], me[15:0]});
            chk(fl === me[21:16]);
            if (me[25]) chk({wr_dest, wr_word} === me[24:22]);
         end
      end
   end
   initial begin
      rst_n = 1'b0; start = 1'b0; ld = 1'b0; opcode = 8'h00;
      modrm_reg = 3'h0; rm_is_mem = 1'b0; bus8 = 1'b0; immediate = 16'h0000;
      ld_val = 48'h0; err_count = 0; checked = 0; seed = 32'h00011231;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (i = 0; i < 15; i = i + 1) begin
         for (j = 0; j < 8; j = j + 1) begin
            seed = lfsr(seed); v[63:32] = seed;
            seed = lfsr(seed); v[31:0] = seed;
            if (!j[2]) v = j[0] ? 64'h8000800080000001 : 64'h80;
            sw_op = TAB[i * 11 + 3 +: 8];
            sw_reg = TAB[i * 11 +: 3];
            run(sw_op, sw_reg, j[0], j[1], j[0], v, 1'b0);
         end
      end
      $display("opcode sweep done");
      run(8'h00, 3'h0, 1'b0, 1'b0, 1'b0, v, 1'b1);
      run(8'hf6, 3'h1, 1'b0, 1'b0, 1'b0, v, 1'b1);
      run(8'h80, 3'h0, 1'b1, 1'b0, 1'b0, v, 1'b1);
      $display("illegal opcode test done");
      finish_test;
   end
endmodule
